// *** hw/cpm_pkg.sv ***
// configuration parameter mailbox package: offsets, codes, defaults, states
// assumes byte-wide access from the serial control port register file
`default_nettype none
package cpm_pkg;
  // ---------------------------------------------------------------------------
  // register offsets on the serial control port
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFF_CMD_LO  = 8'h78;
  localparam logic [7:0] OFF_CMD_HI  = 8'h79;
  localparam logic [7:0] OFF_DATA_LO = 8'h7A;
  localparam logic [7:0] OFF_DATA_HI = 8'h7B;
  localparam logic [7:0] OFF_HOFF_LO = 8'h7C;
  localparam logic [7:0] OFF_HOFF_HI = 8'h7D;
  localparam logic [7:0] OFF_VOFF_LO = 8'h7E;
  localparam logic [7:0] OFF_VOFF_HI = 8'h7F;
  // ---------------------------------------------------------------------------
  // command codes and field layout
  // ---------------------------------------------------------------------------
  localparam logic [3:0] OP_DONE  = 4'h0;
  localparam logic [3:0] OP_READ  = 4'h1;
  localparam logic [3:0] OP_WRITE = 4'h2;
  localparam int         OP_MSB   = 3;
  // ---------------------------------------------------------------------------
  // reset values and per-mode offset defaults
  // ---------------------------------------------------------------------------
  localparam logic [15:0] RST_DATA       = 16'h0000;
  localparam logic [15:0] RST_HOFF       = 16'h00B2;
  localparam logic [15:0] RST_VOFF       = 16'h0026;
  localparam logic [15:0] HOFF_NTSC      = 16'h00B2;
  localparam logic [15:0] HOFF_PAL       = 16'h00E6;
  localparam logic [15:0] HOFF_VGA       = 16'h0084;
  localparam logic [15:0] HOFF_SVGA      = 16'h00B0;
  localparam logic [15:0] HOFF_PAL100    = 16'h00B4;
  localparam logic [15:0] HOFF_PROG_NTSC = 16'h00B2;
  localparam logic [15:0] HOFF_SUPER     = 16'h0122;
  localparam logic [15:0] VOFF_NTSC      = 16'h0026;
  localparam logic [15:0] VOFF_PAL       = 16'h002C;
  localparam logic [15:0] VOFF_VGA       = 16'h0028;
  localparam logic [15:0] VOFF_SVGA      = 16'h0024;
  localparam logic [15:0] VOFF_PAL100    = 16'h0026;
  localparam logic [15:0] VOFF_PROG_NTSC = 16'h0026;
  localparam logic [15:0] VOFF_SUPER_N   = 16'h0026;
  localparam logic [15:0] VOFF_SUPER_P   = 16'h002C;
  // ---------------------------------------------------------------------------
  // timing and states
  // ---------------------------------------------------------------------------
  localparam logic [3:0] CMD_LAT_CYC = 4'h4;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_EXEC = 2'b10
  } cpm_state_t;
endpackage
`default_nettype wire

// *** hw/cpm_param_store.sv ***
// parameter store held by the internal controller: one word per index
// assumes writes come only from the mailbox command engine
`default_nettype none
module cpm_param_store
  import cpm_pkg::*;
#(
  parameter int AW = 8,
  parameter int DW = 16
) (
  // clock, reset, enable
  input  wire logic          mclk_i,
  input  wire logic          resetn_i,
  input  wire logic          ce_i,
  // access
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);
  // ---------------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------------
  logic [DW-1:0] mem_q [2**AW];

  // cleared at reset so unwritten parameters read a defined zero
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      for (int i = 0; i < 2**AW; i++)
        mem_q[i] <= '0;
    end
    else if (ce_i && we_i)
    begin
      mem_q[addr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem_q[addr_i];
endmodule // cpm_param_store
`default_nettype wire

// *** hw/cpm_mailbox.sv ***
// parameter mailbox and output offset shadows on the serial control port
// assumes byte accesses synchronous to mclk_i; mode selects come from elsewhere
//
// Contract
// [RULE1] command and data pair reach controller parameters
// [RULE2] low command byte selects parameter index
// [RULE3] op code low nibble, upper zero, cleared
// [RULE4] read op leaves parameter value in data
// [RULE5] host loads data before write command
// [RULE6] host writes index and op together
// [RULE7] host polls command zero before reading data
// [RULE8] command cleared once write applied
// [RULE9] host delays between polling reads
// [RULE10] sixteen-bit data register, low and high bytes
// [RULE11] horizontal offset shadow in pixels from sync
// [RULE12] horizontal default reloaded on mode change
// [RULE13] vertical offset shadow in lines
// [RULE14] vertical default reloaded on mode change
// [RULE15] unknown op is no operation, clears
`default_nettype none
module cpm_mailbox
  import cpm_pkg::*;
#(
  parameter int PAW = 8
) (
  // clock, reset, enable
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  input  wire logic       ce_i,
  // serial control port register access
  input  wire logic       scp_wr_i,
  input  wire logic       scp_rd_i,
  input  wire logic [7:0] scp_addr_i,
  input  wire logic [7:0] scp_wdata_i,
  output logic      [7:0] scp_rdata_o,
  // output mode selects
  input  wire logic [1:0] output_clock_select_i,
  input  wire logic       scan_type_select_i,
  input  wire logic       tv_standard_select_i,
  // status and offsets
  output logic            busy_o,
  output logic     [15:0] output_horizontal_offset_o,
  output logic     [15:0] output_vertical_offset_o
);
  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  cpm_state_t  st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [7:0]  idx_q, idx_d;
  logic [3:0]  op_q, op_d;
  logic [15:0] data_q, data_d;
  logic [15:0] hoff_q, hoff_d;
  logic [15:0] voff_q, voff_d;
  logic [3:0]  mode_q, mode_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        busy_q, busy_d;
  logic        mem_we;
  logic [15:0] mem_rdata;
  logic [3:0]  mode_now;
  logic [31:0] dflt;
  logic        wr_ok;

  assign mode_now = {output_clock_select_i, scan_type_select_i, tv_standard_select_i};
  // index, op and data take host writes only while the engine is idle
  assign wr_ok    = scp_wr_i && (st_q == ST_IDLE);

  // ---------------------------------------------------------------------------
  // mode default table: {horizontal, vertical}
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] mode_default(input logic [3:0] m);
    logic [31:0] r;
    r = {HOFF_NTSC, VOFF_NTSC};
    case (m)
      4'h0:    r = {HOFF_NTSC, VOFF_NTSC};
      4'h1:    r = {HOFF_PAL, VOFF_PAL};
      4'h2:    r = {HOFF_PROG_NTSC, VOFF_PROG_NTSC};
      4'h3:    r = {HOFF_PAL100, VOFF_PAL100};
      4'h4,
      4'h6:    r = {HOFF_VGA, VOFF_VGA};
      4'h5,
      4'h7:    r = {HOFF_SVGA, VOFF_SVGA};
      4'h8,
      4'hA,
      4'hC,
      4'hE:    r = {HOFF_SUPER, VOFF_SUPER_N};
      default: r = {HOFF_SUPER, VOFF_SUPER_P};
    endcase
    return r;
  endfunction

  assign dflt = mode_default(mode_now);

  // ---------------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------------
  always_comb
  begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    idx_d   = idx_q;
    op_d    = op_q;
    data_d  = data_q;
    hoff_d  = hoff_q;
    voff_d  = voff_q;
    mode_d  = mode_now;
    rdata_d = rdata_q;
    mem_we  = 1'b0;
    // host writes to the mailbox
    if (wr_ok)
    begin
      case (scp_addr_i)
        OFF_CMD_LO:  idx_d = scp_wdata_i; // RULE2
        OFF_CMD_HI:  op_d  = scp_wdata_i[OP_MSB:0]; // RULE3
        OFF_DATA_LO: data_d[7:0]  = scp_wdata_i; // RULE10
        OFF_DATA_HI: data_d[15:8] = scp_wdata_i; // RULE10
        default:     ;
      endcase
    end
    if (scp_wr_i)
    begin
      case (scp_addr_i)
        OFF_HOFF_LO: hoff_d[7:0]  = scp_wdata_i; // RULE11
        OFF_HOFF_HI: hoff_d[15:8] = scp_wdata_i; // RULE11
        OFF_VOFF_LO: voff_d[7:0]  = scp_wdata_i; // RULE13
        OFF_VOFF_HI: voff_d[15:8] = scp_wdata_i; // RULE13
        default:     ;
      endcase
    end
    // mode change beats a same-cycle host write to the offsets
    if (mode_now != mode_q)
    begin
      hoff_d = dflt[31:16]; // RULE12
      voff_d = dflt[15:0]; // RULE14
    end
    // command engine
    case (st_q)
      ST_IDLE:
      begin
        // the high byte write launches the command
        if (wr_ok && scp_addr_i == OFF_CMD_HI && scp_wdata_i[OP_MSB:0] != OP_DONE)
        begin
          st_d  = ST_WAIT;
          cnt_d = 4'h0;
        end
      end
      ST_WAIT:
      begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == CMD_LAT_CYC - 4'h1)
          st_d = ST_EXEC;
      end
      ST_EXEC:
      begin
        if (op_q == OP_READ)
          data_d = mem_rdata; // RULE4 RULE1
        else if (op_q == OP_WRITE)
          mem_we = 1'b1; // RULE1
        // any other op leaves data and parameters alone
        op_d  = OP_DONE; // RULE3 RULE8 RULE15
        idx_d = 8'h00; // RULE8
        st_d  = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    busy_d = (st_d != ST_IDLE);
    // read path, one cycle latency, unmapped reads zero
    if (scp_rd_i)
    begin
      case (scp_addr_i)
        OFF_CMD_LO:  rdata_d = idx_q;
        OFF_CMD_HI:  rdata_d = {4'h0, op_q}; // RULE3
        OFF_DATA_LO: rdata_d = data_q[7:0];
        OFF_DATA_HI: rdata_d = data_q[15:8];
        OFF_HOFF_LO: rdata_d = hoff_q[7:0];
        OFF_HOFF_HI: rdata_d = hoff_q[15:8];
        OFF_VOFF_LO: rdata_d = voff_q[7:0];
        OFF_VOFF_HI: rdata_d = voff_q[15:8];
        default:     rdata_d = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      st_q    <= ST_IDLE;
      cnt_q   <= 4'h0;
      idx_q   <= 8'h00;
      op_q    <= OP_DONE;
      data_q  <= RST_DATA;
      hoff_q  <= RST_HOFF;
      voff_q  <= RST_VOFF;
      mode_q  <= 4'h0;
      rdata_q <= 8'h00;
      busy_q  <= 1'b0;
    end
    else if (ce_i)
    begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      idx_q   <= idx_d;
      op_q    <= op_d;
      data_q  <= data_d;
      hoff_q  <= hoff_d;
      voff_q  <= voff_d;
      mode_q  <= mode_d;
      rdata_q <= rdata_d;
      busy_q  <= busy_d;
    end
  end

  assign scp_rdata_o                = rdata_q;
  assign busy_o                     = busy_q;
  assign output_horizontal_offset_o = hoff_q;
  assign output_vertical_offset_o   = voff_q;

  // ---------------------------------------------------------------------------
  // parameter store
  // ---------------------------------------------------------------------------
  cpm_param_store #(
    .AW (PAW),
    .DW (16)
  ) u_store (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .we_i     (mem_we),
    .addr_i   (idx_q[PAW-1:0]),
    .wdata_i  (data_q),
    .rdata_o  (mem_rdata)
  );

  // ---------------------------------------------------------------------------
  // checks, frozen while the clock enable is low
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i || !ce_i);

  sequence launch_s;
    st_q == ST_IDLE && wr_ok && scp_addr_i == OFF_CMD_HI && scp_wdata_i[3:0] != 4'h0;
  endsequence
  sequence exec_s;
    st_q == ST_EXEC;
  endsequence

  cmd_clear_a: assert property (exec_s |=> op_q == 4'h0 && idx_q == 8'h00) // RULE8
    else $error("command not cleared after execution");
  cmd_latency_a: assert property (launch_s |=> busy_q ##4 st_q == ST_EXEC) // RULE3
    else $error("command did not execute after fixed latency");
  hi_nibble_a: assert property (scp_rd_i && scp_addr_i == OFF_CMD_HI // RULE3
    |=> scp_rdata_o[7:4] == 4'h0)
    else $error("upper command bits not zero");
  read_result_a: assert property ((exec_s and op_q == 4'h1) // RULE4
    |=> data_q == $past(mem_rdata))
    else $error("read result not in data register");
  write_apply_a: assert property ((exec_s and op_q == 4'h2) // RULE10
    |-> mem_we && u_store.wdata_i == data_q)
    else $error("parameter write not applied");
  noop_keep_a: assert property ((exec_s and op_q > 4'h2) // RULE15
    |-> !mem_we ##1 $stable(data_q))
    else $error("unknown op changed state");
  index_sel_a: assert property (mem_we // RULE2
    |=> u_store.mem_q[$past(idx_q[PAW-1:0])] == $past(data_q))
    else $error("parameter not stored at its index");
  hoff_reload_a: assert property (mode_now != mode_q |=> hoff_q == $past(dflt[31:16])) // RULE12
    else $error("horizontal default not reloaded");
  voff_reload_a: assert property (mode_now != mode_q |=> voff_q == $past(dflt[15:0])) // RULE14
    else $error("vertical default not reloaded");
endmodule // cpm_mailbox
`default_nettype wire

// *** testbench/cpm_host_model.sv ***
// host model: byte accesses and mailbox commands on the control port
// assumes the mailbox samples strobes on the rising edge of mclk_i
`default_nettype none
module cpm_host_model
  import cpm_pkg::*;
(
  // clock
  input  wire logic       mclk_i,
  // register port
  output var  logic       scp_wr_o,
  output var  logic       scp_rd_o,
  output var  logic [7:0] scp_addr_o,
  output var  logic [7:0] scp_wdata_o,
  input  wire logic [7:0] scp_rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------------------
  // byte access and command tasks
  // ---------------------------------------------------------------------------
  initial
  begin
    scp_wr_o    = 1'b0;
    scp_rd_o    = 1'b0;
    scp_addr_o  = 8'h00;
    scp_wdata_o = 8'h00;
  end
  // released lines show the inverse, never a stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    scp_wr_o    <= 1'b1;
    scp_addr_o  <= a;
    scp_wdata_o <= d;
    @(posedge mclk_i);
    scp_wr_o    <= 1'b0;
    scp_addr_o  <= ~a;
    scp_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    scp_rd_o   <= 1'b1;
    scp_addr_o <= a;
    @(posedge mclk_i);
    scp_rd_o   <= 1'b0;
    scp_addr_o <= ~a;
    @(posedge mclk_i);
    #1 d = scp_rdata_i;
  endtask
  task automatic cmd(input logic [7:0] idx, input logic [3:0] op, input logic [15:0] dat,
                     output logic [15:0] res, output logic done);
    logic [7:0] b;
    int         n;
    if (op != OP_READ)
    begin
      wr(OFF_DATA_LO, dat[7:0]);
      wr(OFF_DATA_HI, dat[15:8]);
    end
    wr(OFF_CMD_LO, idx);
    wr(OFF_CMD_HI, {4'h0, op});
    done = 1'b0;
    for (n = 0; n < 40 && !done; n++)
    begin
      repeat (3) @(posedge mclk_i);
      rd(OFF_CMD_HI, b);
      done = (b === 8'h00);
    end
    rd(OFF_DATA_LO, res[7:0]);
    rd(OFF_DATA_HI, res[15:8]);
  endtask
endmodule // cpm_host_model
`default_nettype wire

// *** testbench/cpm_mailbox_tb.sv ***
// testbench for the parameter mailbox and output offset shadows
// assumes cpm_host_model drives the register port; ce_i and reset driven here
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module cpm_mailbox_tb
  import cpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------------------
  // signals, tables and instances
  // ---------------------------------------------------------------------------
  logic        mclk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        wr, rd, busy, ok;
  logic [7:0]  addr, wdata, rdata;
  logic [1:0]  clk_sel = 2'b00;
  logic        scan = 1'b0;
  logic        tv_std = 1'b0;
  logic        ce = 1'b1;
  logic [15:0] hoff, voff, r;
  int          mismatches = 0;
  int          samples_checked = 0;
  localparam logic [7:0]  RA [0:7] = '{8'h7C, 8'h7D, 8'h7E, 8'h7F, 8'h78, 8'h79, 8'h7A, 8'h7B};
  localparam logic [7:0]  RV [0:7] = '{8'hB2, 8'h00, 8'h26, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [3:0]  MD [0:8] = '{4'h1, 4'h3, 4'h2, 4'h4, 4'h5, 4'h7, 4'h8, 4'hD, 4'h0};
  localparam logic [15:0] HX [0:8] = '{16'h00E6, 16'h00B4, 16'h00B2, 16'h0084, 16'h00B0,
                                       16'h00B0, 16'h0122, 16'h0122, 16'h00B2};
  localparam logic [15:0] VX [0:8] = '{16'h002C, 16'h0026, 16'h0026, 16'h0028, 16'h0024,
                                       16'h0024, 16'h0026, 16'h002C, 16'h0026};
  cpm_mailbox #(.PAW(8)) uut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce), .scp_wr_i(wr), .scp_rd_i(rd),
    .scp_addr_i(addr), .scp_wdata_i(wdata), .scp_rdata_o(rdata),
    .output_clock_select_i(clk_sel), .scan_type_select_i(scan), .tv_standard_select_i(tv_std),
    .busy_o(busy), .output_horizontal_offset_o(hoff), .output_vertical_offset_o(voff));
  cpm_host_model host (
    .mclk_i(mclk_i), .scp_wr_o(wr), .scp_rd_o(rd), .scp_addr_o(addr),
    .scp_wdata_o(wdata), .scp_rdata_i(rdata));
  // ---------------------------------------------------------------------------
  // clock, checks, verdict
  // ---------------------------------------------------------------------------
  initial
  begin
    forever #20 mclk_i = ~mclk_i;
  end
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    `CHK(d, e)
  endtask
  task automatic conclude();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // generous: the whole sequence needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    mismatches++;
    conclude();
  end
  initial
  begin
    repeat (16) @(posedge mclk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 8; i++) chk_rd(RA[i], RV[i]);
    host.cmd(8'h05, OP_WRITE, 16'hA55A, r, ok);
    `CHK(ok, 1'b1)
    chk_rd(OFF_CMD_LO, 8'h00);
    host.cmd(8'hFF, OP_WRITE, 16'h0F0F, r, ok);
    `CHK(ok, 1'b1)
    host.cmd(8'h05, OP_READ, 16'h0000, r, ok);
    `CHK(r, 16'hA55A)
    host.cmd(8'hFF, OP_READ, 16'h0000, r, ok);
    `CHK(r, 16'h0F0F)
    host.cmd(8'h06, OP_READ, 16'hFFFF, r, ok);
    `CHK(r, 16'h0000)
    host.cmd(8'h05, 4'h3, 16'h1234, r, ok);
    `CHK(r, 16'h1234)
    `CHK(ok, 1'b1)
    host.cmd(8'h05, OP_READ, 16'h0000, r, ok);
    `CHK(r, 16'hA55A)
    host.wr(OFF_CMD_HI, 8'hF1);
    #1 `CHK(busy, 1'b1)
    chk_rd(OFF_CMD_HI, 8'h01);
    repeat (10) @(posedge mclk_i);
    chk_rd(OFF_CMD_HI, 8'h00);
    host.wr(OFF_HOFF_LO, 8'h34);
    host.wr(OFF_HOFF_HI, 8'h12);
    host.wr(OFF_VOFF_LO, 8'h78);
    host.wr(OFF_VOFF_HI, 8'h56);
    #1 `CHK(hoff, 16'h1234)
    `CHK(voff, 16'h5678)
    chk_rd(OFF_VOFF_HI, 8'h56);
    for (int i = 0; i < 9; i++)
    begin
      @(posedge mclk_i);
      clk_sel <= MD[i][3:2];
      scan    <= MD[i][1];
      tv_std  <= MD[i][0];
      repeat (3) @(posedge mclk_i);
      #1 `CHK(hoff, HX[i])
      `CHK(voff, VX[i])
    end
    // enable low must freeze the horizontal shadow against a host write
    host.wr(OFF_VOFF_LO, 8'h99);
    @(posedge mclk_i);
    ce <= 1'b0;
    host.wr(OFF_HOFF_LO, 8'hAA);
    #1 `CHK(hoff, 16'h00B2)
    `CHK(voff, 16'h0099)
    // reset again mid-run: shadows and parameter store return to reset values
    @(posedge mclk_i);
    ce       <= 1'b1;
    resetn_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'b1;
    chk_rd(OFF_VOFF_LO, 8'h26);
    host.cmd(8'h05, OP_READ, 16'h0000, r, ok);
    `CHK(r, 16'h0000)
    conclude();
  end
endmodule // cpm_mailbox_tb
`default_nettype wire
